// ===== design/port_pkg.sv
`default_nettype none
package port_pkg;
  localparam int          PIN_COUNT         = 6;
  localparam int          ADDR_WIDTH        = 8;
  localparam int          DATA_WIDTH        = 32;
  localparam int          SYNC_STAGES       = 2;
  localparam int          INT_PIN_INDEX     = 2;
  localparam logic [7:0]  OFF_PIN_INPUT     = 8'h00;
  localparam logic [7:0]  OFF_DIRECTION     = 8'h04;
  localparam logic [7:0]  OFF_OUTPUT_VALUE  = 8'h08;
  localparam logic [7:0]  OFF_MCU_CONTROL   = 8'h0C;
  localparam logic [7:0]  OFF_INT_FLAG      = 8'h10;
  localparam int          PUD_BIT           = 6;
  localparam int          SENSE_LSB         = 0;
  localparam int          SENSE_MSB         = 1;
  localparam logic [7:0]  MCU_CONTROL_RESET = 8'h00;
  localparam logic [5:0]  DIRECTION_RESET   = 6'h00;
  localparam logic [5:0]  OUTPUT_RESET      = 6'h00;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_CHANGE,
    SENSE_FALL,
    SENSE_RISE
  } sense_t;
endpackage
`default_nettype wire

// ===== design/reg_access_if.sv
`default_nettype none
interface reg_access_if;
  import port_pkg::*;
  logic                  wr;
  logic [ADDR_WIDTH-1:0] addr;
  logic [DATA_WIDTH-1:0] wdata;
  logic [DATA_WIDTH-1:0] rdata;
  logic                  hit;

  modport bus  (output wr, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ===== design/port_apb_slave.sv
`default_nettype none
module port_apb_slave
  import port_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [DATA_WIDTH-1:0] pwdata,
  output var  logic [DATA_WIDTH-1:0] prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  reg_access_if.bus                  acc
);
  logic setup;

  assign setup     = psel && !penable;
  assign acc.addr  = paddr;
  assign acc.wdata = pwdata;
  // A write lands only on the edge that completes the access phase.
  assign acc.wr    = psel && penable && pready && pwrite && acc.hit;

  // The answer is prepared in the setup cycle so every bus output is a flop.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (pwrite || !acc.hit) ? '0 : acc.rdata;
      pready  <= 1'b1;
      pslverr <= !acc.hit;
    end else if (pready) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/port_sync.sv
`default_nettype none
module port_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== design/port_pin_control.sv
`default_nettype none
module port_pin_control
  import port_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESETN,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [ADDR_WIDTH-1:0] PADDR,
  input  wire logic [DATA_WIDTH-1:0] PWDATA,
  output var  logic [DATA_WIDTH-1:0] PRDATA,
  output var  logic                  PREADY,
  output var  logic                  PSLVERR,
  input  wire logic [N-1:0]          PIN_IN,
  output var  logic [N-1:0]          PIN_OUT,
  output var  logic [N-1:0]          PIN_OE,
  output var  logic [N-1:0]          PIN_PULLUP,
  input  wire logic [N-1:0]          PULLUP_OVERRIDE_ENABLE,
  input  wire logic [N-1:0]          PULLUP_OVERRIDE_VALUE,
  input  wire logic [N-1:0]          DIRECTION_OVERRIDE_ENABLE,
  input  wire logic [N-1:0]          DIRECTION_OVERRIDE_VALUE,
  input  wire logic [N-1:0]          VALUE_OVERRIDE_ENABLE,
  input  wire logic [N-1:0]          VALUE_OVERRIDE_VALUE,
  input  wire logic [N-1:0]          TOGGLE_OVERRIDE_ENABLE,
  input  wire logic [N-1:0]          INPUT_ENABLE_OVERRIDE_ENABLE,
  input  wire logic [N-1:0]          INPUT_ENABLE_OVERRIDE_VALUE,
  input  wire logic [N-1:0]          EXT_INT_ENABLE,
  input  wire logic                  SLEEP_DEEP,
  output var  logic [N-1:0]          ALTERNATE_DIGITAL_INPUT,
  output var  logic                  INPUT_CLAMP_REQUEST,
  output var  logic                  EXT_INT_FLAG
);
  reg_access_if acc ();

  logic [N-1:0] direction_register;
  logic [N-1:0] output_value_register;
  logic [7:0]   mcu_control;
  logic [N-1:0] pin_sync;
  logic [N-1:0] input_enable;
  logic [N-1:0] gated_in;
  logic [N-1:0] next_oe;
  logic [N-1:0] next_level;
  logic [N-1:0] next_pullup;
  logic [N-1:0] next_value;
  logic [N-1:0] wr_mask;
  logic         pullup_disable;
  logic         wr_pin;
  logic         wr_dir;
  logic         wr_value;
  logic         wr_mcu;
  logic         wr_flag;
  logic         int_prev;
  logic         int_event;
  logic         flag_set;
  logic [SYNC_STAGES:0] sync_fill;
  sense_t       sense;

  port_apb_slave u_apb (
    .clk     (CLK_SYS),
    .resetn  (RESETN),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .acc     (acc)
  );

  assign wr_pin         = acc.wr && (acc.addr == OFF_PIN_INPUT);
  assign wr_dir         = acc.wr && (acc.addr == OFF_DIRECTION);
  assign wr_value       = acc.wr && (acc.addr == OFF_OUTPUT_VALUE);
  assign wr_mcu         = acc.wr && (acc.addr == OFF_MCU_CONTROL);
  assign wr_flag        = acc.wr && (acc.addr == OFF_INT_FLAG);
  assign wr_mask        = acc.wdata[N-1:0];
  assign pullup_disable = mcu_control[PUD_BIT];
  assign sense          = sense_t'(mcu_control[SENSE_MSB:SENSE_LSB]);

  always_comb begin
    acc.hit   = 1'b1;
    acc.rdata = '0;
    unique case (acc.addr)
      OFF_PIN_INPUT:    acc.rdata[N-1:0] = pin_sync;
      OFF_DIRECTION:    acc.rdata[N-1:0] = direction_register;
      OFF_OUTPUT_VALUE: acc.rdata[N-1:0] = output_value_register;
      OFF_MCU_CONTROL:  acc.rdata[7:0]   = mcu_control;
      OFF_INT_FLAG:     acc.rdata[0]     = EXT_INT_FLAG;
      default:          acc.hit          = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      direction_register <= DIRECTION_RESET;
    end else if (wr_dir) begin
      direction_register <= wr_mask;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      mcu_control <= MCU_CONTROL_RESET;
    end else if (wr_mcu) begin
      mcu_control <= acc.wdata[7:0];
    end
  end

  // A plain write or a software toggle, and an alternate-function toggle, in one
  // cycle both apply: the alternate-function toggle inverts whatever the access would store.
  always_comb begin
    next_value = wr_value ? wr_mask : output_value_register;
    if (wr_pin) begin
      next_value = next_value ^ wr_mask;
    end
    next_value = next_value ^ TOGGLE_OVERRIDE_ENABLE;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      output_value_register <= OUTPUT_RESET;
    end else begin
      output_value_register <= next_value;
    end
  end

  always_comb begin
    next_oe     = (DIRECTION_OVERRIDE_ENABLE & DIRECTION_OVERRIDE_VALUE)
                | (~DIRECTION_OVERRIDE_ENABLE & direction_register);
    next_level  = (VALUE_OVERRIDE_ENABLE & VALUE_OVERRIDE_VALUE)
                | (~VALUE_OVERRIDE_ENABLE & output_value_register);
    next_pullup = (PULLUP_OVERRIDE_ENABLE & PULLUP_OVERRIDE_VALUE)
                | (~PULLUP_OVERRIDE_ENABLE & ~direction_register & output_value_register
                   & {N{~pullup_disable}});
  end

  // The pad drivers clear without a clock edge so pins float and pull-ups
  // stay off for as long as reset is low, even with the clock stopped.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PIN_OE     <= '0;
      PIN_OUT    <= '0;
      PIN_PULLUP <= '0;
    end else begin
      PIN_OE     <= next_oe;
      PIN_OUT    <= next_level;
      PIN_PULLUP <= next_pullup;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      INPUT_CLAMP_REQUEST <= 1'b0;
    end else begin
      INPUT_CLAMP_REQUEST <= SLEEP_DEEP;
    end
  end

  // The clamp grounds the input ahead of the buffer, so floating pins draw
  // no current in deep sleep; interrupt pins must keep seeing the pad.
  assign input_enable = (INPUT_ENABLE_OVERRIDE_ENABLE & INPUT_ENABLE_OVERRIDE_VALUE)
                      | (~INPUT_ENABLE_OVERRIDE_ENABLE
                         & ~({N{INPUT_CLAMP_REQUEST}} & ~EXT_INT_ENABLE));
  assign gated_in     = PIN_IN & input_enable;

  // One flop only: consumers that are not clock sources resynchronise it.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ALTERNATE_DIGITAL_INPUT <= '0;
    end else begin
      ALTERNATE_DIGITAL_INPUT <= gated_in;
    end
  end

  port_sync #(.WIDTH(N)) u_sync (
    .clk      (CLK_SYS),
    .resetn   (RESETN),
    .async_in (gated_in),
    .sync_out (pin_sync)
  );

  // The clamp pulls a high pin low in sleep, so the release on wake is seen
  // as a rising edge and sets the flag even with the interrupt disabled.
  always_comb begin
    unique case (sense)
      SENSE_LOW:    int_event = !pin_sync[INT_PIN_INDEX];
      SENSE_CHANGE: int_event = pin_sync[INT_PIN_INDEX] != int_prev;
      SENSE_FALL:   int_event = int_prev && !pin_sync[INT_PIN_INDEX];
      SENSE_RISE:   int_event = !int_prev && pin_sync[INT_PIN_INDEX];
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      int_prev <= 1'b0;
    end else begin
      int_prev <= pin_sync[INT_PIN_INDEX];
    end
  end

  // The synchroniser reads zero until it has filled after reset, and the
  // edge detector needs one more cycle, so events wait until both are real.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      sync_fill <= '0;
    end else begin
      sync_fill <= {sync_fill[SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign flag_set = int_event && sync_fill[SYNC_STAGES];

  // A new event in the clearing cycle wins over the write-one clear.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      EXT_INT_FLAG <= 1'b0;
    end else if (flag_set) begin
      EXT_INT_FLAG <= 1'b1;
    end else if (wr_flag && acc.wdata[0]) begin
      EXT_INT_FLAG <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  oe_source_a: assert property ($past(RESETN) |-> PIN_OE == $past(
      (DIRECTION_OVERRIDE_ENABLE & DIRECTION_OVERRIDE_VALUE)
      | (~DIRECTION_OVERRIDE_ENABLE & direction_register)))
    else $error("Driver enable does not follow its source.");
  pullup_gate_a: assert property ($past(RESETN) |-> (PIN_PULLUP
      & ~$past(PULLUP_OVERRIDE_ENABLE) & ($past(direction_register)
      | ~$past(output_value_register) | {N{$past(pullup_disable)}})) == '0)
    else $error("Pull-up enabled outside input with value one.");
  level_source_a: assert property ($past(RESETN) |-> PIN_OUT == $past(
      (VALUE_OVERRIDE_ENABLE & VALUE_OVERRIDE_VALUE)
      | (~VALUE_OVERRIDE_ENABLE & output_value_register)))
    else $error("Driven level does not follow its source.");
  sw_toggle_a: assert property ((wr_pin && TOGGLE_OVERRIDE_ENABLE == '0) |=>
      output_value_register == ($past(output_value_register) ^ $past(wr_mask)))
    else $error("Pin input write did not toggle the value.");
  hw_toggle_a: assert property ((!acc.wr && TOGGLE_OVERRIDE_ENABLE != '0) |=>
      output_value_register == ~($past(output_value_register) ^ ~$past(TOGGLE_OVERRIDE_ENABLE)))
    else $error("Toggle override did not invert the value.");
  clamp_request_a: assert property ($rose(SLEEP_DEEP) |=> INPUT_CLAMP_REQUEST)
    else $error("Clamp request missed deep sleep.");
  reset_float_a: assert property (disable iff (1'b0) !RESETN |=>
      (PIN_OE == '0 && PIN_PULLUP == '0))
    else $error("Pin driven or pulled during reset.");
  wake_flag_a: assert property ((sense == SENSE_RISE && $rose(pin_sync[INT_PIN_INDEX]))
      |=> EXT_INT_FLAG)
    else $error("Rising edge did not set the interrupt flag.");
  sync_read_a: assert property ($changed(gated_in) |-> ##2 pin_sync == $past(gated_in, 2))
    else $error("Pin input read not two cycles behind pad.");
  clamp_ground_a: assert property (INPUT_CLAMP_REQUEST |->
      (gated_in & ~EXT_INT_ENABLE & ~INPUT_ENABLE_OVERRIDE_ENABLE) == '0)
    else $error("Clamped input not grounded.");
  clamp_release_a: assert property ($fell(SLEEP_DEEP) |=> !INPUT_CLAMP_REQUEST)
    else $error("Clamp request held after wake.");
  int_unclamped_a: assert property (INPUT_CLAMP_REQUEST |->
      (EXT_INT_ENABLE & ~INPUT_ENABLE_OVERRIDE_ENABLE & ~input_enable) == '0)
    else $error("Interrupt pin input clamped.");
  ie_override_a: assert property (
      (INPUT_ENABLE_OVERRIDE_ENABLE & (input_enable ^ INPUT_ENABLE_OVERRIDE_VALUE)) == '0)
    else $error("Input enable ignores its override.");
  alt_input_a: assert property ($past(RESETN) |->
      ALTERNATE_DIGITAL_INPUT == $past(gated_in))
    else $error("Alternate input not one flop behind pad.");
  pud_off_a: assert property (($past(RESETN) && $past(pullup_disable)) |->
      (PIN_PULLUP & ~$past(PULLUP_OVERRIDE_ENABLE)) == '0)
    else $error("Pull-up on while pull-ups are disabled.");
  pullup_ovr_a: assert property ($past(RESETN) |-> ((PIN_PULLUP
      ^ $past(PULLUP_OVERRIDE_VALUE)) & $past(PULLUP_OVERRIDE_ENABLE)) == '0)
    else $error("Pull-up ignores its override.");
  dir_drive_a: assert property ($past(RESETN) |-> ((PIN_OE
      ^ $past(direction_register)) & ~$past(DIRECTION_OVERRIDE_ENABLE)) == '0)
    else $error("Driver enable does not follow direction.");
  value_drive_a: assert property ($past(RESETN) |-> ((PIN_OUT
      ^ $past(output_value_register)) & ~$past(VALUE_OVERRIDE_ENABLE)) == '0)
    else $error("Driven level does not follow output value.");
  flag_set_a: assert property (flag_set |=> EXT_INT_FLAG)
    else $error("Interrupt event did not set the flag.");
  flag_clear_a: assert property ((wr_flag && acc.wdata[0] && !flag_set) |=>
      !EXT_INT_FLAG)
    else $error("Flag not cleared by a write of one.");
endmodule
`default_nettype wire

// ===== verif/pin_pad_model.sv
`default_nettype none
// External circuitry on the pads: an outside driver, the pull-up, or a floating line.
module pin_pad_model
  import port_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe,
  input  wire logic [PIN_COUNT-1:0] pin_pullup,
  input  wire logic [PIN_COUNT-1:0] ext_en,
  input  wire logic [PIN_COUNT-1:0] ext_lvl,
  output var  logic [PIN_COUNT-1:0] pad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PIN_COUNT-1:0] float_lvl = 6'h2A;
  // A floating pad changes every cycle, so a stale level never passes for a real one.
  always @(posedge clk) begin
    float_lvl <= ~float_lvl;
  end
  // The pin driver wins over the outside driver; the pull-up only matters on an idle line.
  always_comb begin
    pad = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
        | (~pin_oe & ~ext_en & (pin_pullup | float_lvl));
  end
endmodule
`default_nettype wire

// ===== verif/port_pin_control_tb.sv
`default_nettype none
module port_pin_control_tb
  import port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [PIN_COUNT-1:0] pins_t;
  logic        clk     = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep   = 1'b0;
  logic        clamp;
  logic        int_flag;
  pins_t       pu_oe   = 6'h00;
  pins_t       pu_ov   = 6'h00;
  pins_t       dd_oe   = 6'h00;
  pins_t       dd_ov   = 6'h00;
  pins_t       pv_oe   = 6'h00;
  pins_t       pv_ov   = 6'h00;
  pins_t       tg_oe   = 6'h00;
  pins_t       ie_oe   = 6'h00;
  pins_t       ie_ov   = 6'h00;
  pins_t       int_en  = 6'h00;
  pins_t       ext_en  = 6'h3F;
  pins_t       ext_lvl = 6'h36;
  pins_t       pin_in;
  pins_t       pin_out;
  pins_t       pin_oe;
  pins_t       pin_pu;
  pins_t       adi;
  int          err_total  = 0;
  int          num_checks = 0;

  always #5 clk = ~clk;

  port_pin_control uut (.CLK_SYS(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLUP(pin_pu), .PULLUP_OVERRIDE_ENABLE(pu_oe), .PULLUP_OVERRIDE_VALUE(pu_ov),
    .DIRECTION_OVERRIDE_ENABLE(dd_oe), .DIRECTION_OVERRIDE_VALUE(dd_ov),
    .VALUE_OVERRIDE_ENABLE(pv_oe), .VALUE_OVERRIDE_VALUE(pv_ov),
    .TOGGLE_OVERRIDE_ENABLE(tg_oe), .INPUT_ENABLE_OVERRIDE_ENABLE(ie_oe),
    .INPUT_ENABLE_OVERRIDE_VALUE(ie_ov), .EXT_INT_ENABLE(int_en), .SLEEP_DEEP(sleep),
    .ALTERNATE_DIGITAL_INPUT(adi), .INPUT_CLAMP_REQUEST(clamp), .EXT_INT_FLAG(int_flag));

  pin_pad_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pad(pin_in));

  task give_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task check_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task check_pin(input pins_t got, input pins_t exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: pins %b, wanted %b", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check_reg(r, exp);
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    pins_t       exp;
    repeat (16) @(posedge clk);
    check_pin(pin_oe | pin_pu, 6'h00);
    resetn <= 1'b1;
    rd_chk(OFF_MCU_CONTROL, {24'h0, MCU_CONTROL_RESET});
    rd_chk(OFF_DIRECTION, {26'h0, DIRECTION_RESET});
    rd_chk(OFF_OUTPUT_VALUE, {26'h0, OUTPUT_RESET});
    // Value before direction keeps each pin on a legal path out of hi-Z.
    wr(OFF_OUTPUT_VALUE, 32'h2A);
    wr(OFF_DIRECTION, 32'h0C);
    tick(2);
    check_pin(pin_oe, 6'h0C);
    check_pin(pin_out & pin_oe, 6'h08);
    check_pin(pin_pu, 6'h22);
    wr(OFF_MCU_CONTROL, 32'h40);
    tick(2);
    check_pin(pin_pu, 6'h00);
    rd_chk(OFF_MCU_CONTROL, 32'h40);
    wr(OFF_MCU_CONTROL, 32'h0);
    exp = (6'h0C & 6'h2A) | (~6'h0C & 6'h36);
    rd_chk(OFF_PIN_INPUT, {26'h0, exp});
    check_pin(adi, exp);
    wr(OFF_PIN_INPUT, 32'h05);
    wr(OFF_PIN_INPUT, 32'h00);
    rd_chk(OFF_OUTPUT_VALUE, 32'h2F);
    apb(1'b1, 8'h14, 32'hFF, r, e);
    check_reg({31'h0, e}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, r, e);
    check_reg(r, 32'h0);
    rd_chk(OFF_DIRECTION, 32'h0C);
    @(posedge clk);
    pu_oe <= 6'h3F;
    pu_ov <= 6'h15;
    dd_oe <= 6'h3F;
    dd_ov <= 6'h33;
    pv_oe <= 6'h0F;
    pv_ov <= 6'h05;
    tick(2);
    check_pin(pin_pu, 6'h15);
    check_pin(pin_oe, 6'h33);
    check_pin(pin_out & pin_oe, 6'h21);
    @(posedge clk);
    tg_oe <= 6'h01;
    @(posedge clk);
    {tg_oe, pu_oe, dd_oe, pv_oe} <= '0;
    rd_chk(OFF_OUTPUT_VALUE, 32'h2E);
    wr(OFF_DIRECTION, 32'h0);
    @(posedge clk);
    int_en <= 6'h10;
    ie_oe  <= 6'h03;
    ie_ov  <= 6'h02;
    for (int m = 0; m < 4; m++) begin
      wr(OFF_MCU_CONTROL, 32'(m));
      wr(OFF_INT_FLAG, 32'h1);
      @(posedge clk);
      sleep <= 1'b1;
      tick(4);
      check_pin({5'h0, clamp}, 6'h01);
      check_pin(adi, 6'h12);
      @(posedge clk);
      sleep <= 1'b0;
      tick(4);
      check_pin({5'h0, int_flag}, 6'h01);
      rd_chk(OFF_INT_FLAG, 32'h1);
    end
    wr(OFF_INT_FLAG, 32'h1);
    rd_chk(OFF_INT_FLAG, 32'h0);
    wr(OFF_DIRECTION, 32'h3F);
    tick(2);
    check_pin(pin_oe, 6'h3F);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    check_pin(pin_oe | pin_pu, 6'h00);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(OFF_DIRECTION, 32'h0);
    // A high interrupt pin must not look low while the chain refills; sense is back at SENSE_LOW after reset.
    rd_chk(OFF_INT_FLAG, 32'h0);
    give_verdict();
  end

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
